// >>> hw/anps_regs.sv
// Next page transmit word, summary status and their companion registers
//
// Notes on behaviour
// RULE1: more-pages flag, writable, tells partner whether another next page follows.
// RULE2: bit 14 of next page word ignores writes and reads zero.
// RULE3: message page flag at bit 13, reset one, selects formatted or unformatted.
// RULE4: will-comply bit, reset zero, says whether we can comply with message.
// RULE5: toggle bit, read-only, holds inverse of previously exchanged word's toggle.
// RULE6: 11-bit code resets to the null message page value.
// RULE7: summary status bit 15 ignores writes, reads zero.
// RULE8: crossover bit follows enable and force; tracks swaps live when auto.
// RULE9: crossover bit one means pairs swapped, zero means normal.
// RULE10: receive error latch sets on error, clears only on error counter read.
// RULE11: latch reports an error since last read of counter at offset 15h.
// RULE12: bit 12 mirrors ten-meg polarity bit, cleared by that register's read.
// RULE13: polarity bit one means inverted polarity, zero means correct.
// RULE14: error in same cycle as clearing read keeps the latch set.
//
// The strobed register port is this design's own decision.

`include "anps_map.svh"

module anps_regs #(
    parameter int ADDR_WIDTH    = 5,
    parameter int ERR_CNT_WIDTH = 16
) (
    input  wire logic                      core_clk,
    input  wire logic                      srst,
    input  wire logic [ADDR_WIDTH-1:0]     regAddr,
    input  wire logic [15:0]               regWrData,
    input  wire logic                      regWrEn,
    input  wire logic                      regRdEn,
    output logic      [15:0]               regRdData,
    input  wire logic                      rxErrorPin,
    input  wire logic                      polarityInvertedPin,
    input  wire logic                      autoSwapState,
    input  wire logic                      wordExchanged,
    input  wire logic                      exchangedToggle,
    output anps_pkg::anps_np_word_type     nextPageWord,
    output logic                           pairsSwapped,
    output logic                           intrOut
);

    // Elaboration check on parameters
    if (ADDR_WIDTH < 5)
    begin : gBadAddr
        $error("ADDR_WIDTH must be at least 5");
    end
    if (ERR_CNT_WIDTH < 1 || ERR_CNT_WIDTH > 16)
    begin : gBadCnt
        $error("ERR_CNT_WIDTH must be 1 to 16");
    end

    // Pin synchronisers: first stage read only by second
    logic rxErrMeta_q;
    logic rxErrSync_q;
    logic polMeta_q;
    logic polSync_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rxErrMeta_q <= 1'h0;
            rxErrSync_q <= 1'h0;
            polMeta_q   <= 1'h0;
            polSync_q   <= 1'h0;
        end
        else
        begin
            rxErrMeta_q <= rxErrorPin;
            rxErrSync_q <= rxErrMeta_q;
            polMeta_q   <= polarityInvertedPin;
            polSync_q   <= polMeta_q;
        end
    end

    // Address decode
    logic hitNextPage;
    logic hitSummary;
    logic hitRxErrCnt;
    logic hitTenMeg;
    logic hitPhyCtrl;
    logic hitIntStatus;
    logic hitIntClear;
    logic hitIntEnable;

    always_comb
    begin
        hitNextPage  = (regAddr == ADDR_WIDTH'(`ANPS_OFF_NEXT_PAGE));
        hitSummary   = (regAddr == ADDR_WIDTH'(`ANPS_OFF_SUMMARY));
        hitRxErrCnt  = (regAddr == ADDR_WIDTH'(`ANPS_OFF_RXERR_CNT));
        hitTenMeg    = (regAddr == ADDR_WIDTH'(`ANPS_OFF_TENMEG));
        hitPhyCtrl   = (regAddr == ADDR_WIDTH'(`ANPS_OFF_PHY_CTRL));
        hitIntStatus = (regAddr == ADDR_WIDTH'(`ANPS_OFF_INT_STATUS));
        hitIntClear  = (regAddr == ADDR_WIDTH'(`ANPS_OFF_INT_CLEAR));
        hitIntEnable = (regAddr == ADDR_WIDTH'(`ANPS_OFF_INT_ENABLE));
    end

    // Next page transmit word
    anps_pkg::anps_np_word_type npWord_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            npWord_q.morePages    <= `ANPS_RST_MORE_PAGES;
            npWord_q.reservedZero <= 1'h0;
            npWord_q.messagePage  <= `ANPS_RST_MSG_PAGE;
            npWord_q.willComply   <= `ANPS_RST_WILL_COMPLY;
            npWord_q.toggleSent   <= `ANPS_RST_TOGGLE;
            // RULE6: null page code
            npWord_q.code         <= `ANPS_RST_CODE;
        end
        else
        begin
            if (regWrEn && hitNextPage)
            begin
                // RULE1: more pages wanted
                npWord_q.morePages   <= regWrData[`ANPS_BIT_MORE_PAGES];
                // RULE3: message or unformatted
                npWord_q.messagePage <= regWrData[`ANPS_BIT_MSG_PAGE];
                // RULE4: comply answer
                npWord_q.willComply  <= regWrData[`ANPS_BIT_WILL_COMPLY];
                npWord_q.code        <= regWrData[`ANPS_CODE_HI:`ANPS_CODE_LO];
            end
            // RULE2: reserved bit held zero
            npWord_q.reservedZero <= 1'h0;
            // RULE5: inverse of last exchanged toggle
            if (wordExchanged)
            begin
                npWord_q.toggleSent <= ~exchangedToggle;
            end
        end
    end

    // Crossover control register
    anps_pkg::anps_xover_ctrl_type xoverCtrl_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            xoverCtrl_q.autoCrossoverEnable <= `ANPS_RST_AUTO_XOVER;
            xoverCtrl_q.crossoverForce      <= `ANPS_RST_XOVER_FORCE;
        end
        else if (regWrEn && hitPhyCtrl)
        begin
            xoverCtrl_q.autoCrossoverEnable <= regWrData[`ANPS_BIT_AUTO_XOVER];
            xoverCtrl_q.crossoverForce      <= regWrData[`ANPS_BIT_XOVER_FORCE];
        end
    end

    // Crossover state: force wins, then automatic swap, else normal
    logic crossover_d;
    logic crossover_q;

    always_comb
    begin
        // RULE8: enable and force steer
        if (xoverCtrl_q.crossoverForce)
        begin
            crossover_d = 1'h1;
        end
        else if (xoverCtrl_q.autoCrossoverEnable)
        begin
            crossover_d = autoSwapState;
        end
        else
        begin
            crossover_d = 1'h0;
        end
    end

    // RULE9: one means pairs swapped
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            crossover_q <= 1'h0;
        end
        else
        begin
            crossover_q <= crossover_d;
        end
    end

    // Receive error latch and counter
    logic                     rxErrLatch_q;
    logic [ERR_CNT_WIDTH-1:0] rxErrCount_q;
    logic                     rxErrCntRead;

    always_comb
    begin
        rxErrCntRead = regRdEn && hitRxErrCnt;
    end

    // RULE10: clears only on counter read
    // RULE14: new error beats the clear
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rxErrLatch_q <= 1'h0;
        end
        else if (rxErrSync_q)
        begin
            rxErrLatch_q <= 1'h1;
        end
        else if (rxErrCntRead)
        begin
            rxErrLatch_q <= 1'h0;
        end
    end

    // RULE11: counter saturates so a read never wraps to zero errors
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rxErrCount_q <= '0;
        end
        else if (rxErrSync_q)
        begin
            if (rxErrCntRead)
            begin
                rxErrCount_q <= ERR_CNT_WIDTH'(1);
            end
            else if (rxErrCount_q != '1)
            begin
                rxErrCount_q <= rxErrCount_q + ERR_CNT_WIDTH'(1);
            end
        end
        else if (rxErrCntRead)
        begin
            rxErrCount_q <= '0;
        end
    end

    // Polarity latch shared by both status views
    logic polLatch_q;

    // RULE12: clears on ten-meg read only
    // RULE13: one means inverted
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            polLatch_q <= 1'h0;
        end
        else if (polSync_q)
        begin
            polLatch_q <= 1'h1;
        end
        else if (regRdEn && hitTenMeg)
        begin
            polLatch_q <= 1'h0;
        end
    end

    // Interrupt events
    anps_pkg::anps_evt_type evtNow;
    logic                   polLatchPrev_q;
    logic                   crossoverPrev_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            polLatchPrev_q  <= 1'h0;
            crossoverPrev_q <= 1'h0;
        end
        else
        begin
            polLatchPrev_q  <= polLatch_q;
            crossoverPrev_q <= crossover_q;
        end
    end

    always_comb
    begin
        evtNow.rxError   = rxErrSync_q;
        evtNow.polarity  = polLatch_q && !polLatchPrev_q;
        evtNow.crossover = crossover_q != crossoverPrev_q;
        evtNow.pageSent  = wordExchanged;
    end

    logic [`ANPS_EVT_COUNT-1:0] intStatus_q;
    logic [`ANPS_EVT_COUNT-1:0] intEnable_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            intEnable_q <= `ANPS_RST_INT_ENABLE;
        end
        else if (regWrEn && hitIntEnable)
        begin
            intEnable_q <= regWrData[`ANPS_EVT_COUNT-1:0];
        end
    end

    // Sticky bits; a set in the clearing cycle survives
    for (genvar i = 0; i < `ANPS_EVT_COUNT; i++)
    begin : gSticky
        always_ff @(posedge core_clk)
        begin
            if (srst)
            begin
                intStatus_q[i] <= 1'h0;
            end
            else if (evtNow[i])
            begin
                intStatus_q[i] <= 1'h1;
            end
            else if (regWrEn && hitIntClear && regWrData[i])
            begin
                intStatus_q[i] <= 1'h0;
            end
        end
    end

    // Level interrupt, one cycle behind the sticky bits
    logic intr_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            intr_q <= 1'h0;
        end
        else
        begin
            intr_q <= |(intStatus_q & intEnable_q);
        end
    end

    // Read data, valid only in the cycle after the strobe
    logic [15:0] rdData_d;
    logic [15:0] rdData_q;

    always_comb
    begin
        rdData_d = 16'h0000;
        if (hitNextPage)
        begin
            rdData_d = nextPageWord;
            // RULE2: reads zero
            rdData_d[`ANPS_BIT_NP_RSVD] = 1'h0;
        end
        else if (hitSummary)
        begin
            // RULE7: bit 15 reads zero
            rdData_d[`ANPS_BIT_SUM_RSVD]    = 1'h0;
            rdData_d[`ANPS_BIT_CROSSOVER]   = crossover_q;
            rdData_d[`ANPS_BIT_RXERR_LATCH] = rxErrLatch_q;
            // RULE12: mirror of ten-meg bit
            rdData_d[`ANPS_BIT_POLARITY]    = polLatch_q;
        end
        else if (hitRxErrCnt)
        begin
            rdData_d[ERR_CNT_WIDTH-1:0] = rxErrCount_q;
        end
        else if (hitTenMeg)
        begin
            rdData_d[`ANPS_BIT_TENMEG_POL] = polLatch_q;
        end
        else if (hitPhyCtrl)
        begin
            rdData_d[`ANPS_BIT_AUTO_XOVER]  = xoverCtrl_q.autoCrossoverEnable;
            rdData_d[`ANPS_BIT_XOVER_FORCE] = xoverCtrl_q.crossoverForce;
        end
        else if (hitIntStatus)
        begin
            rdData_d[`ANPS_EVT_COUNT-1:0] = intStatus_q;
        end
        else if (hitIntEnable)
        begin
            rdData_d[`ANPS_EVT_COUNT-1:0] = intEnable_q;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rdData_q <= 16'h0000;
        end
        else if (regRdEn)
        begin
            rdData_q <= rdData_d;
        end
        else
        begin
            rdData_q <= 16'h0000;
        end
    end

    // Outputs straight from flops
    always_comb
    begin
        regRdData    = rdData_q;
        nextPageWord = npWord_q;
        pairsSwapped = crossover_q;
        intrOut      = intr_q;
    end

endmodule // anps_regs

// >>> hw/anps_map.svh
// Register offsets, field positions and reset values of the next page and status bank
`ifndef ANPS_MAP_SVH
`define ANPS_MAP_SVH
`define ANPS_OFF_NEXT_PAGE   5'h07
`define ANPS_OFF_SUMMARY     5'h10
`define ANPS_OFF_RXERR_CNT   5'h15
`define ANPS_OFF_TENMEG      5'h18
`define ANPS_OFF_PHY_CTRL    5'h19
`define ANPS_OFF_INT_STATUS  5'h1C
`define ANPS_OFF_INT_CLEAR   5'h1D
`define ANPS_OFF_INT_ENABLE  5'h1E
`define ANPS_BIT_MORE_PAGES  15
`define ANPS_BIT_NP_RSVD     14
`define ANPS_BIT_MSG_PAGE    13
`define ANPS_BIT_WILL_COMPLY 12
`define ANPS_BIT_TOGGLE      11
`define ANPS_CODE_HI         10
`define ANPS_CODE_LO         0
`define ANPS_BIT_SUM_RSVD    15
`define ANPS_BIT_CROSSOVER   14
`define ANPS_BIT_RXERR_LATCH 13
`define ANPS_BIT_POLARITY    12
`define ANPS_BIT_TENMEG_POL  4
`define ANPS_BIT_AUTO_XOVER  15
`define ANPS_BIT_XOVER_FORCE 14
`define ANPS_RST_MORE_PAGES  1'h0
`define ANPS_RST_MSG_PAGE    1'h1
`define ANPS_RST_WILL_COMPLY 1'h0
`define ANPS_RST_TOGGLE      1'h0
`define ANPS_RST_CODE        11'h001
`define ANPS_RST_AUTO_XOVER  1'h1
`define ANPS_RST_XOVER_FORCE 1'h0
`define ANPS_RST_INT_ENABLE  4'h0
`define ANPS_EVT_RXERR       0
`define ANPS_EVT_POLARITY    1
`define ANPS_EVT_CROSSOVER   2
`define ANPS_EVT_PAGE_SENT   3
`define ANPS_EVT_COUNT       4
`endif

// >>> hw/anps_pkg.sv
// Types shared by the next page and status register bank
package anps_pkg;
    typedef struct packed {
        logic        morePages;
        logic        reservedZero;
        logic        messagePage;
        logic        willComply;
        logic        toggleSent;
        logic [10:0] code;
    } anps_np_word_type;

    typedef struct packed {
        logic pageSent;
        logic crossover;
        logic polarity;
        logic rxError;
    } anps_evt_type;

    typedef struct packed {
        logic autoCrossoverEnable;
        logic crossoverForce;
    } anps_xover_ctrl_type;
endpackage

// >>> sim/anps_checker.sv
// Port-level assertions for the next page and status bank
`include "anps_map.svh"
module anps_checker #(
    parameter int ADDR_WIDTH    = 5,
    parameter int ERR_CNT_WIDTH = 16
) (
    input wire logic                       core_clk,
    input wire logic                       srst,
    input wire logic [ADDR_WIDTH-1:0]      regAddr,
    input wire logic [15:0]                regWrData,
    input wire logic                       regWrEn,
    input wire logic                       regRdEn,
    input wire logic [15:0]                regRdData,
    input wire logic                       rxErrorPin,
    input wire logic                       polarityInvertedPin,
    input wire logic                       autoSwapState,
    input wire logic                       wordExchanged,
    input wire logic                       exchangedToggle,
    input wire anps_pkg::anps_np_word_type nextPageWord,
    input wire logic                       pairsSwapped,
    input wire logic                       intrOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] xoverCtrl_q;
    logic [3:0] intEn_q;
    // Shadows of control writes; bank never stalls so writes land next edge
    always_ff @(posedge core_clk)
    begin
        if (srst)
            xoverCtrl_q <= 2'h2;
        else if (regWrEn && regAddr == `ANPS_OFF_PHY_CTRL)
            xoverCtrl_q <= regWrData[15:14];
    end
    always_ff @(posedge core_clk)
    begin
        if (srst)
            intEn_q <= 4'h0;
        else if (regWrEn && regAddr == `ANPS_OFF_INT_ENABLE)
            intEn_q <= regWrData[3:0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    AST_NP_RESET: assert property ($past(srst) |-> nextPageWord == 16'h2001)
        else $error("next page word not at reset value");
    AST_NP_RSVD: assert property (nextPageWord.reservedZero == 1'h0)
        else $error("next page bit 14 set");
    AST_NP_READ: assert property ($past(regRdEn) && $past(regAddr) == `ANPS_OFF_NEXT_PAGE
        |-> regRdData == $past(nextPageWord))
        else $error("next page read differs from word");
    AST_TOGGLE: assert property (wordExchanged |=> nextPageWord.toggleSent
        == !$past(exchangedToggle))
        else $error("toggle not inverse of exchanged");
    AST_XOVER: assert property (!$past(srst) |-> pairsSwapped == ($past(xoverCtrl_q[0])
        | ($past(xoverCtrl_q[1]) & $past(autoSwapState))))
        else $error("crossover state wrong");
    AST_SUM_RSVD: assert property ($past(regRdEn) && $past(regAddr) == `ANPS_OFF_SUMMARY
        |-> regRdData[15] == 1'h0)
        else $error("summary bit 15 set");
    AST_SUM_XOVER: assert property ($past(regRdEn) && $past(regAddr) == `ANPS_OFF_SUMMARY
        |-> regRdData[14] == $past(pairsSwapped))
        else $error("summary crossover differs");
    AST_RD_IDLE: assert property (!$past(regRdEn) |-> regRdData == 16'h0000)
        else $error("read data outside read slot");
    AST_INT_MASK: assert property ($past(intEn_q) == 4'h0 |-> !intrOut)
        else $error("interrupt while all masked");
    cover property (wordExchanged);
    cover property ($rose(intrOut));
    cover property (regRdEn && regAddr == `ANPS_OFF_RXERR_CNT);
endmodule // anps_checker

bind anps_regs anps_checker #(
    .ADDR_WIDTH    (ADDR_WIDTH),
    .ERR_CNT_WIDTH (ERR_CNT_WIDTH)
) anps_checker_i (
    .core_clk            (core_clk),
    .srst                (srst),
    .regAddr             (regAddr),
    .regWrData           (regWrData),
    .regWrEn             (regWrEn),
    .regRdEn             (regRdEn),
    .regRdData           (regRdData),
    .rxErrorPin          (rxErrorPin),
    .polarityInvertedPin (polarityInvertedPin),
    .autoSwapState       (autoSwapState),
    .wordExchanged       (wordExchanged),
    .exchangedToggle     (exchangedToggle),
    .nextPageWord        (nextPageWord),
    .pairsSwapped        (pairsSwapped),
    .intrOut             (intrOut)
);

// >>> sim/anps_link_partner.sv
// Behavioural link partner and line conditions
module anps_link_partner (
    input wire logic core_clk,
    output logic     rxErrorPin,
    output logic     polarityInvertedPin,
    output logic     autoSwapState,
    output logic     wordExchanged,
    output logic     exchangedToggle
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {rxErrorPin, polarityInvertedPin, autoSwapState, wordExchanged} = 4'h0;
        exchangedToggle = 1'h0;
    end
    task automatic exchange(input logic tog);
        @(posedge core_clk);
        wordExchanged   <= 1'h1;
        exchangedToggle <= tog;
        @(posedge core_clk);
        wordExchanged   <= 1'h0;
        // Stale toggle flipped so it is never trusted outside the pulse
        exchangedToggle <= ~tog;
    endtask
    task automatic pulse_error();
        @(posedge core_clk);
        rxErrorPin <= 1'h1;
        @(posedge core_clk);
        rxErrorPin <= 1'h0;
    endtask
    task automatic set_line(input logic pol, input logic swp);
        @(posedge core_clk);
        polarityInvertedPin <= pol;
        autoSwapState       <= swp;
    endtask
endmodule // anps_link_partner

// >>> sim/tb_top.sv
// Self-checking bench for the next page and status bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       core_clk;
    logic                       srst;
    logic [4:0]                 regAddr;
    logic [15:0]                regWrData;
    logic                       regWrEn;
    logic                       regRdEn;
    logic [15:0]                regRdData;
    logic                       rxErr;
    logic                       polInv;
    logic                       swapSt;
    logic                       wordEx;
    logic                       exTog;
    anps_pkg::anps_np_word_type nextPageWord;
    logic                       pairsSwapped;
    logic                       intrOut;
    int                         mismatches;
    int                         numChecks;

    anps_regs anps_regs_i (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .rxErrorPin(rxErr), .polarityInvertedPin(polInv), .autoSwapState(swapSt),
        .wordExchanged(wordEx), .exchangedToggle(exTog), .nextPageWord(nextPageWord),
        .pairsSwapped(pairsSwapped), .intrOut(intrOut));
    anps_link_partner anps_link_partner_i (.core_clk(core_clk), .rxErrorPin(rxErr),
        .polarityInvertedPin(polInv), .autoSwapState(swapSt), .wordExchanged(wordEx),
        .exchangedToggle(exTog));

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWrEn   <= 1'h1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn <= 1'h0;
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regRdEn <= 1'h1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'h0;
        #1;
        check(nm, regRdData, exp);
    endtask
    task automatic t_next_page();
        rdc("np reset", 5'h07, 16'h2001);
        wr(5'h07, 16'hFFFF);
        rdc("np ones", 5'h07, 16'hB7FF);
        check("np port", nextPageWord, 16'hB7FF);
        wr(5'h07, 16'h0000);
        rdc("np zero", 5'h07, 16'h0000);
        wr(5'h07, 16'h8000);
        rdc("np more", 5'h07, 16'h8000);
        wr(5'h07, 16'h0000);
    endtask
    task automatic t_toggle();
        anps_link_partner_i.exchange(1'h0);
        rdc("tog one", 5'h07, 16'h0800);
        anps_link_partner_i.exchange(1'h1);
        rdc("tog zero", 5'h07, 16'h0000);
    endtask
    task automatic t_xover();
        anps_link_partner_i.set_line(1'h0, 1'h1);
        rdc("auto swap", 5'h10, 16'h4000);
        anps_link_partner_i.set_line(1'h0, 1'h0);
        rdc("auto normal", 5'h10, 16'h0000);
        wr(5'h19, 16'h4000);
        rdc("forced", 5'h10, 16'h4000);
        check("forced port", {15'h0000, pairsSwapped}, 16'h0001);
        wr(5'h19, 16'h0000);
        anps_link_partner_i.set_line(1'h0, 1'h1);
        rdc("auto off", 5'h10, 16'h0000);
        wr(5'h19, 16'h8000);
        anps_link_partner_i.set_line(1'h0, 1'h0);
    endtask
    task automatic t_rx_error();
        // Last crossover swap still raises its event; let it land before clearing
        repeat (3) @(posedge core_clk);
        wr(5'h1D, 16'h000F);
        wr(5'h1E, 16'h0001);
        anps_link_partner_i.pulse_error();
        repeat (4) @(posedge core_clk);
        rdc("err set", 5'h10, 16'h2000);
        rdc("err kept", 5'h10, 16'h2000);
        rdc("int status", 5'h1C, 16'h0001);
        check("intr high", {15'h0000, intrOut}, 16'h0001);
        rdc("err count", 5'h15, 16'h0001);
        rdc("err cleared", 5'h10, 16'h0000);
        wr(5'h1D, 16'h000F);
        repeat (2) @(posedge core_clk);
        #1;
        check("intr low", {15'h0000, intrOut}, 16'h0000);
        rdc("clear reg", 5'h1D, 16'h0000);
        anps_link_partner_i.pulse_error();
        rdc("race count", 5'h15, 16'h0000);
        rdc("race latch", 5'h10, 16'h2000);
        rdc("race recount", 5'h15, 16'h0001);
    endtask
    task automatic t_polarity();
        anps_link_partner_i.set_line(1'h1, 1'h0);
        repeat (4) @(posedge core_clk);
        rdc("pol set", 5'h10, 16'h1000);
        anps_link_partner_i.set_line(1'h0, 1'h0);
        repeat (4) @(posedge core_clk);
        rdc("pol kept", 5'h10, 16'h1000);
        rdc("tenmeg", 5'h18, 16'h0010);
        rdc("pol cleared", 5'h10, 16'h0000);
    endtask
    task automatic t_refused();
        wr(5'h10, 16'hFFFF);
        rdc("sum ro", 5'h10, 16'h0000);
        wr(5'h03, 16'hFFFF);
        rdc("unmapped", 5'h03, 16'h0000);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run is about a hundred and ten cycles; 20000 means a hang
    initial
    begin
        #200000;
        mismatches++;
        close_out();
    end
    initial
    begin
        srst = 1'h1;
        regAddr = 5'h00;
        regWrData = 16'h0000;
        {regWrEn, regRdEn} = 2'h0;
        repeat (5) @(posedge core_clk);
        srst <= 1'h0;
        t_next_page();
        t_toggle();
        t_xover();
        t_rx_error();
        t_polarity();
        t_refused();
        close_out();
    end
endmodule // tb_top
